// *** far_end_sink.sv ***
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------------
// receiving mac model: takes bytes, stalls as commanded
// ----------------------------------------------------------------------
module far_end_sink (
  input  wire logic              ref_clk_i,
  input  wire logic              out_valid_i,
  input  wire ptp_tc_pkg::beat_t out_beat_i,
  input  wire logic [1:0]        mode_i,
  output logic                   out_ready_o
);
  ptp_tc_pkg::beat_t rx_q[$];
  ptp_tc_pkg::beat_t beat_s;
  logic              take;
  logic              tog;
  logic [7:0]        cnt;

  initial
  begin
    out_ready_o = 1'b0;
    take = 1'b0;
    tog = 1'b0;
    cnt = 8'h00;
  end

  // mode 0 always ready, 1 every other cycle, 2 stalled for 40 cycles first
  always @(posedge ref_clk_i)
  begin
    if (take)
      rx_q.push_back(beat_s);
    tog <= ~tog;
    cnt <= (mode_i != 2'h2) ? 8'h00 : ((cnt == 8'hFF) ? cnt : cnt + 8'h01);
    out_ready_o <= #1 (mode_i == 2'h0) || (mode_i == 2'h1 && tog) || (mode_i == 2'h2 && cnt >= 8'h28);
  end

  // sampled mid-cycle so a capture never races the buffer flops
  always @(negedge ref_clk_i)
  begin
    take = out_valid_i && out_ready_o;
    beat_s = out_beat_i;
  end
endmodule

`default_nettype wire

// *** ptp_tc_correction_rewrite.sv ***
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// RULE1: e2e mode b: cf plus tx minus rx
// RULE2: rx stamp from reserved bytes, then zeroed
// RULE3: mode b delay_req also subtracts asymmetry
// RULE4: update runs alone, frame never lengthened
// RULE5: analyzers must classify sync and delay_req
// RULE6: p2p sync adds residence and path delay
// RULE7: engine sends pdelay_req, keeps t3 readable
// RULE8: engine computes link delay by halving
// RULE9: engine sends software t3, zero cf
// RULE10: modified method uses e2e egress action
// RULE11: ingress sync takes peer subtract, cf rewrite
// RULE12: peer subtract: cf minus stamp plus path
// RULE13: ingress pdelay writes stamp to reserved bytes
// RULE14: ingress sync asym add; pdelay_resp asym add
// RULE15: egress sync cf plus raw plus local
// RULE16: egress pdelay_req sub-add, minus asymmetry
// RULE17: alternative write-save queues seq id, stamp
// RULE18: egress pdelay_resp sub-add with reserved stamp
// RULE19: unmatched frame passes, stamp discarded
// RULE20: new fcs replaces old, inverted if bad
// RULE21: cf signed 64-bit, reserved math mod second
// RULE22: rewrite in flight, no added bytes
module ptp_tc_correction_rewrite (
  input  wire logic                 ref_clk_i,
  input  wire logic                 reset_i,
  input  wire logic                 in_valid_i,
  output logic                      in_ready_o,
  input  wire ptp_tc_pkg::beat_t    in_beat_i,
  input  wire logic                 desc_valid_i,
  output logic                      desc_ready_o,
  input  wire ptp_tc_pkg::tc_desc_t desc_i,
  input  wire ptp_tc_pkg::tc_cfg_t  cfg_i,
  input  wire logic [31:0]          raw_nanosecond_stamp_i,
  output logic                      out_valid_o,
  input  wire logic                 out_ready_i,
  output ptp_tc_pkg::beat_t         out_beat_o,
  output logic                      ts_save_o,
  output ptp_tc_pkg::ts_rec_t       ts_rec_o,
  output logic                      stamp_flush_o
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    ptp_tc_pkg::phase_t     phase;
    ptp_tc_pkg::tc_action_t action;
    logic                   cf_we;
    logic                   rsv_we;
    logic                   mod;
    logic [63:0]            cf;
    logic [31:0]            rsv;
    logic [15:0]            cf_off;
    logic [15:0]            rsv_off;
    logic [15:0]            idx;
    logic [31:0]            hold;
    logic [2:0]             hcnt;
    logic [31:0]            crc_in;
    logic [31:0]            crc_out;
    logic [31:0]            fcs;
    logic [1:0]             fcs_idx;
    ptp_tc_pkg::beat_t [1:0] buf_mem;
    logic                   wr;
    logic                   rd;
    logic [1:0]             cnt;
    logic                   ts_save;
    ptp_tc_pkg::ts_rec_t    ts;
    logic                   flush;
  } st_t;

  st_t st;
  st_t next_st;

  // ----------------------------------------------------------------------
  // arithmetic helpers
  // ----------------------------------------------------------------------
  // signed ns to scaled ns (ns << 16), sign kept
  function automatic logic [63:0] scaled(input logic [31:0] ns_val);
    return {{16{ns_val[31]}}, ns_val, ptp_tc_pkg::CF_FRAC};
  endfunction

  // reserved bytes carry ns within the second, so wrap at one second (RULE21)
  function automatic logic [31:0] sub_mod_sec(input logic [31:0] a,
                                              input logic [31:0] b);
    logic [31:0] d;
    d = a - b;
    if (a < b)
      d = d + ptp_tc_pkg::NS_PER_SEC;
    return d;
  endfunction

  function automatic logic [31:0] crc_byte(input logic [31:0] crc,
                                           input logic [7:0]  d);
    logic [31:0] c;
    c = crc;
    for (int i = 0; i < 8; i++)
      c = (c >> 1) ^ ((c[0] ^ d[i]) ? ptp_tc_pkg::CRC_POLY : 32'h00000000);
    return c;
  endfunction

  // ----------------------------------------------------------------------
  // field calculation at start of frame
  // ----------------------------------------------------------------------
  logic [31:0] tx_ns;
  logic [31:0] rx_ns;
  logic [63:0] calc_cf;
  logic [31:0] calc_rsv;
  logic        calc_cf_we;
  logic        calc_rsv_we;

  // stamp is the time the first byte is taken
  always_comb
  begin
    tx_ns       = raw_nanosecond_stamp_i + cfg_i.local_corr;
    rx_ns       = raw_nanosecond_stamp_i - cfg_i.local_corr;
    calc_cf     = desc_i.cf_orig;
    calc_rsv    = desc_i.rsv_orig;
    calc_cf_we  = 1'b0;
    calc_rsv_we = 1'b0;
    unique case (desc_i.action)
      ptp_tc_pkg::ACT_E2E_B:
      begin
        calc_cf     = desc_i.cf_orig + scaled(sub_mod_sec(tx_ns, desc_i.rsv_orig)); // RULE1 RULE10
        calc_cf_we  = 1'b1;
        calc_rsv    = 32'h00000000; // RULE2
        calc_rsv_we = 1'b1;
      end
      ptp_tc_pkg::ACT_PEER_SUB:
      begin
        calc_cf    = desc_i.cf_orig - scaled(rx_ns) + scaled(cfg_i.path_delay); // RULE12 RULE6
        calc_cf_we = 1'b1; // RULE11
      end
      ptp_tc_pkg::ACT_ING_WRITE:
      begin
        calc_rsv    = rx_ns; // RULE13
        calc_rsv_we = 1'b1;
        calc_cf_we  = (desc_i.asym != ptp_tc_pkg::ASYM_NONE); // RULE14
      end
      ptp_tc_pkg::ACT_EGR_ADD:
      begin
        calc_cf    = desc_i.cf_orig + scaled(tx_ns); // RULE15
        calc_cf_we = 1'b1;
      end
      ptp_tc_pkg::ACT_EGR_SUB_ADD:
      begin
        calc_cf    = desc_i.cf_orig + scaled(sub_mod_sec(tx_ns, desc_i.rsv_orig)); // RULE16 RULE18
        calc_cf_we = 1'b1;
      end
      ptp_tc_pkg::ACT_WRITE_SAVE, ptp_tc_pkg::ACT_PASS:
      begin
        calc_cf_we = 1'b0; // RULE17 RULE19
      end
      default:
      begin
        calc_cf_we = 1'b0;
      end
    endcase
    // asymmetry is signed ns, applied only where the cf is rewritten
    if (calc_cf_we && desc_i.asym == ptp_tc_pkg::ASYM_ADD)
      calc_cf = calc_cf + scaled(cfg_i.asymmetry); // RULE14
    else if (calc_cf_we && desc_i.asym == ptp_tc_pkg::ASYM_SUB)
      calc_cf = calc_cf - scaled(cfg_i.asymmetry); // RULE3 RULE16
  end

  // ----------------------------------------------------------------------
  // datapath
  // ----------------------------------------------------------------------
  logic              take;
  logic              sof;
  logic              pop;
  logic              push;
  ptp_tc_pkg::beat_t push_beat;
  logic [63:0]       cur_cf;
  logic [31:0]       cur_rsv;
  logic              cur_cf_we;
  logic              cur_rsv_we;
  logic [15:0]       cur_idx;
  logic [15:0]       ck;
  logic [15:0]       rk;
  logic [63:0]       cf_sh;
  logic [31:0]       rsv_sh;
  logic [7:0]        b;
  logic [31:0]       crc_o_n;
  logic              fcs_bad;

  // new frames wait for a descriptor; fcs emission blocks the input
  assign in_ready_o   = (st.cnt != 2'd2) && (st.phase != ptp_tc_pkg::PH_FCS)
                        && (st.phase != ptp_tc_pkg::PH_IDLE || desc_valid_i);
  assign take         = in_valid_i && in_ready_o;
  assign sof          = take && st.phase == ptp_tc_pkg::PH_IDLE;
  assign desc_ready_o = sof; // RULE5
  assign pop          = out_ready_i && st.cnt != 2'd0;
  assign out_valid_o  = st.cnt != 2'd0;
  assign out_beat_o   = st.buf_mem[st.rd];
  assign ts_save_o    = st.ts_save;
  assign ts_rec_o     = st.ts;
  assign stamp_flush_o = st.flush;

  // byte substitution and the hold line that keeps the last four bytes,
  // so the trailing fcs can be swapped without knowing the length ahead
  always_comb
  begin
    next_st    = st;
    next_st.ts_save = 1'b0;
    next_st.flush   = 1'b0;
    push       = 1'b0;
    push_beat  = '0;
    cur_cf     = sof ? calc_cf : st.cf;
    cur_rsv    = sof ? calc_rsv : st.rsv;
    cur_cf_we  = sof ? calc_cf_we : st.cf_we;
    cur_rsv_we = sof ? calc_rsv_we : st.rsv_we;
    cur_idx    = sof ? ptp_tc_pkg::LEN_ZERO : st.idx;
    ck         = cur_idx - (sof ? desc_i.cf_off : st.cf_off);
    rk         = cur_idx - (sof ? desc_i.rsv_off : st.rsv_off);
    cf_sh      = cur_cf << {ck[2:0], 3'b000};
    rsv_sh     = cur_rsv << {rk[1:0], 3'b000};
    crc_o_n    = st.crc_out;
    fcs_bad    = 1'b0;
    b          = in_beat_i.data;
    // big-endian field bytes replace the frame bytes in place
    if (cur_cf_we && cur_idx >= (sof ? desc_i.cf_off : st.cf_off)
        && ck < 16'(ptp_tc_pkg::CF_BYTES))
      b = cf_sh[63:56]; // RULE11 RULE22
    else if (cur_rsv_we && cur_idx >= (sof ? desc_i.rsv_off : st.rsv_off)
             && rk < 16'(ptp_tc_pkg::RSV_BYTES))
      b = rsv_sh[31:24]; // RULE2 RULE13
    if (sof)
    begin
      next_st.action = desc_i.action;
      next_st.cf     = calc_cf;
      next_st.rsv    = calc_rsv;
      next_st.cf_we  = calc_cf_we;
      next_st.rsv_we = calc_rsv_we;
      next_st.mod    = calc_cf_we || calc_rsv_we;
      next_st.cf_off = desc_i.cf_off;
      next_st.rsv_off = desc_i.rsv_off;
      next_st.phase  = ptp_tc_pkg::PH_BODY;
      if (desc_i.action == ptp_tc_pkg::ACT_WRITE_SAVE)
      begin
        next_st.ts_save = 1'b1; // RULE17
        next_st.ts      = {desc_i.seq_id, tx_ns};
      end
      if (desc_i.action == ptp_tc_pkg::ACT_PASS)
        next_st.flush = 1'b1; // RULE19
    end
    if (take)
    begin
      next_st.crc_in = crc_byte(st.crc_in, in_beat_i.data);
      if (st.hcnt == 3'd4)
      begin
        push      = 1'b1;
        push_beat = '{data: st.hold[7:0], last: 1'b0};
        crc_o_n   = crc_byte(st.crc_out, st.hold[7:0]);
      end
      next_st.crc_out = crc_o_n;
      next_st.hold    = {b, st.hold[31:8]};
      next_st.hcnt    = (st.hcnt == 3'd4) ? 3'd4 : st.hcnt + 3'd1;
      next_st.idx     = cur_idx + ptp_tc_pkg::LEN_ONE;
      if (in_beat_i.last)
      begin
        fcs_bad         = next_st.crc_in != ptp_tc_pkg::CRC_RESIDUE;
        next_st.phase   = ptp_tc_pkg::PH_FCS;
        next_st.fcs_idx = 2'd0;
        // untouched frames keep their own fcs, bad or not
        if (next_st.mod)
          next_st.fcs = fcs_bad ? crc_o_n : ~crc_o_n; // RULE20
        else
          next_st.fcs = next_st.hold; // RULE19
      end
    end
    else if (st.phase == ptp_tc_pkg::PH_FCS && st.cnt != 2'd2)
    begin
      push            = 1'b1;
      push_beat       = '{data: st.fcs[7:0], last: st.fcs_idx == 2'd3};
      next_st.fcs     = {8'h00, st.fcs[31:8]};
      next_st.fcs_idx = st.fcs_idx + 2'd1;
      if (st.fcs_idx == 2'd3)
      begin
        next_st.phase   = ptp_tc_pkg::PH_IDLE;
        next_st.hcnt    = 3'd0;
        next_st.crc_in  = ptp_tc_pkg::CRC_INIT;
        next_st.crc_out = ptp_tc_pkg::CRC_INIT;
        next_st.cf      = 64'h0000000000000000;
        next_st.rsv     = 32'h00000000;
      end
    end
    // two-entry buffer: a receiver stall loses no byte
    if (push)
    begin
      next_st.buf_mem[st.wr] = push_beat;
      next_st.wr             = ~st.wr;
    end
    if (pop)
      next_st.rd = ~st.rd;
    next_st.cnt = st.cnt + {1'b0, push} - {1'b0, pop};
  end

  // single state register; runs with no processor help (RULE4)
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      st         <= '0;
      st.crc_in  <= ptp_tc_pkg::CRC_INIT;
      st.crc_out <= ptp_tc_pkg::CRC_INIT;
    end
    else
      st <= next_st;
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  logic [15:0] in_len;
  logic [15:0] out_len;
  logic [15:0] last_len;

  // byte counts per frame on both sides, for the length check
  always_ff @(posedge ref_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      in_len   <= 16'h0000;
      out_len  <= 16'h0000;
      last_len <= 16'h0000;
    end
    else
    begin
      if (take)
        in_len <= in_beat_i.last ? 16'h0000 : in_len + 16'h0001;
      if (take && in_beat_i.last)
        last_len <= in_len + 16'h0001;
      if (pop)
        out_len <= out_beat_o.last ? 16'h0000 : out_len + 16'h0001;
    end
  end

  a_e2e_cf_sum: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RULE1
    sof && desc_i.action == ptp_tc_pkg::ACT_E2E_B && desc_i.asym == ptp_tc_pkg::ASYM_NONE
    |=> st.cf == $past(desc_i.cf_orig) + scaled(sub_mod_sec($past(tx_ns), $past(desc_i.rsv_orig))))
    else $error("e2e correction sum wrong");

  a_rsv_zeroed: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RULE2
    sof && desc_i.action == ptp_tc_pkg::ACT_E2E_B |=> st.rsv_we && st.rsv == 32'h00000000)
    else $error("reserved bytes not cleared");

  a_asym_sub: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RULE3
    sof && desc_i.action == ptp_tc_pkg::ACT_E2E_B && desc_i.asym == ptp_tc_pkg::ASYM_SUB
    |=> st.cf == $past(desc_i.cf_orig) - scaled($past(cfg_i.asymmetry))
      + scaled(sub_mod_sec($past(tx_ns), $past(desc_i.rsv_orig))))
    else $error("asymmetry not subtracted");

  a_len_kept: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RULE22
    pop && out_beat_o.last |-> out_len + 16'h0001 == last_len)
    else $error("frame length changed");

  a_peer_sub: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RULE12
    sof && desc_i.action == ptp_tc_pkg::ACT_PEER_SUB && desc_i.asym == ptp_tc_pkg::ASYM_NONE
    |=> st.cf_we && st.cf == $past(desc_i.cf_orig) - scaled($past(rx_ns))
      + scaled($past(cfg_i.path_delay)))
    else $error("peer subtract wrong");

  a_ing_stamp: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RULE13
    sof && desc_i.action == ptp_tc_pkg::ACT_ING_WRITE
    |=> st.rsv_we && st.rsv == $past(raw_nanosecond_stamp_i) - $past(cfg_i.local_corr))
    else $error("ingress stamp not written");

  a_egr_add: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RULE15
    sof && desc_i.action == ptp_tc_pkg::ACT_EGR_ADD && desc_i.asym == ptp_tc_pkg::ASYM_NONE
    |=> st.cf == $past(desc_i.cf_orig) + scaled($past(tx_ns)))
    else $error("egress add wrong");

  a_save_pulse: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RULE17
    sof && desc_i.action == ptp_tc_pkg::ACT_WRITE_SAVE
    |=> ts_save_o && ts_rec_o.seq_id == $past(desc_i.seq_id) ##1 !ts_save_o)
    else $error("save pulse wrong");

  a_pass_clean: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RULE19
    sof && desc_i.action == ptp_tc_pkg::ACT_PASS
    |=> stamp_flush_o && !st.mod && !st.cf_we && !st.rsv_we)
    else $error("unmatched frame altered");

  a_fcs_phase: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RULE20
    take && in_beat_i.last |=> st.phase == ptp_tc_pkg::PH_FCS && !in_ready_o)
    else $error("fcs phase not entered");

  c_e2e_frame: cover property (@(posedge ref_clk_i) disable iff (reset_i)
    sof && desc_i.action == ptp_tc_pkg::ACT_E2E_B ##[1:300] pop && out_beat_o.last);

  c_stall_full: cover property (@(posedge ref_clk_i) disable iff (reset_i)
    st.cnt == 2'd2 && !out_ready_i ##1 st.cnt == 2'd2);

  c_bad_fcs_mod: cover property (@(posedge ref_clk_i) disable iff (reset_i)
    take && in_beat_i.last && fcs_bad && st.mod);

endmodule

`default_nettype wire

// *** ptp_tc_pkg.sv ***
package ptp_tc_pkg;

  // ----------------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------------
  localparam logic [31:0] NS_PER_SEC   = 32'h3B9ACA00;  // one second in ns
  localparam int unsigned CF_BYTES     = 8;             // correction field width
  localparam int unsigned RSV_BYTES    = 4;             // reserved header bytes
  localparam int unsigned FCS_BYTES    = 4;
  localparam int unsigned BUF_DEPTH    = 2;
  localparam logic [15:0] CF_FRAC      = 16'h0000;      // scaled-ns fraction
  localparam logic [31:0] CRC_POLY     = 32'hEDB88320;  // reflected crc-32
  localparam logic [31:0] CRC_INIT     = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_RESIDUE  = 32'hDEBB20E3;  // good-frame remainder
  localparam logic [15:0] LEN_ZERO     = 16'h0000;
  localparam logic [15:0] LEN_ONE      = 16'h0001;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ACT_PASS        = 3'b000,
    ACT_E2E_B       = 3'b001,
    ACT_PEER_SUB    = 3'b010,
    ACT_ING_WRITE   = 3'b011,
    ACT_EGR_ADD     = 3'b100,
    ACT_EGR_SUB_ADD = 3'b101,
    ACT_WRITE_SAVE  = 3'b110
  } tc_action_t;

  typedef enum logic [1:0] {
    ASYM_NONE = 2'b00,
    ASYM_ADD  = 2'b01,
    ASYM_SUB  = 2'b10
  } asym_sel_t;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_BODY = 2'b01,
    PH_FCS  = 2'b10
  } phase_t;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } beat_t;

  typedef struct packed {
    tc_action_t  action;
    asym_sel_t   asym;
    logic [63:0] cf_orig;
    logic [31:0] rsv_orig;
    logic [15:0] cf_off;
    logic [15:0] rsv_off;
    logic [15:0] seq_id;
  } tc_desc_t;

  typedef struct packed {
    logic [31:0] local_corr;
    logic [31:0] asymmetry;
    logic [31:0] path_delay;
  } tc_cfg_t;

  typedef struct packed {
    logic [15:0] seq_id;
    logic [31:0] stamp;
  } ts_rec_t;

endpackage

// *** testbench.sv ***
`timescale 1ns/10ps
`default_nettype none

module testbench;
  logic                  ref_clk_i = 1'b0;
  logic                  reset_i = 1'b1;
  logic                  in_valid_i = 1'b0;
  logic                  in_ready_o;
  ptp_tc_pkg::beat_t     in_beat_i = '0;
  logic                  desc_valid_i = 1'b0;
  logic                  desc_ready_o;
  ptp_tc_pkg::tc_desc_t  desc_i = '0;
  ptp_tc_pkg::tc_cfg_t   cfg_i = '{32'h00000064, 32'h0000000A, 32'h000003E8};
  logic [31:0]           raw_nanosecond_stamp_i = '0;
  logic                  out_valid_o;
  logic                  out_ready_i;
  ptp_tc_pkg::beat_t     out_beat_o;
  logic                  ts_save_o;
  ptp_tc_pkg::ts_rec_t   ts_rec_o;
  logic                  stamp_flush_o;
  logic [1:0]            mode = 2'h0;
  int                    bad_count = 0;
  int                    checks = 0;
  int                    first_wait;
  logic                  sv;
  logic                  fl;
  logic [47:0]           rec;

  // ----------------------------------------------------------------------
  // clock, design and receiver
  // ----------------------------------------------------------------------
  always #2.5 ref_clk_i = ~ref_clk_i;

  ptp_tc_correction_rewrite ptp_tc_correction_rewrite_i (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .in_valid_i(in_valid_i),
    .in_ready_o(in_ready_o), .in_beat_i(in_beat_i), .desc_valid_i(desc_valid_i),
    .desc_ready_o(desc_ready_o), .desc_i(desc_i), .cfg_i(cfg_i),
    .raw_nanosecond_stamp_i(raw_nanosecond_stamp_i), .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i), .out_beat_o(out_beat_o), .ts_save_o(ts_save_o),
    .ts_rec_o(ts_rec_o), .stamp_flush_o(stamp_flush_o));

  far_end_sink far_end_sink_i (
    .ref_clk_i(ref_clk_i), .out_valid_i(out_valid_o), .out_beat_i(out_beat_o),
    .mode_i(mode), .out_ready_o(out_ready_i));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic report_and_stop;
    if (bad_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // reflected crc-32, kept apart from the design's own code
  function automatic logic [31:0] crc_of(input logic [7:0] q[$]);
    logic [31:0] c;
    c = ptp_tc_pkg::CRC_INIT;
    foreach (q[i])
    begin
      c = c ^ {24'h000000, q[i]};
      for (int b = 0; b < 8; b++)
        c = c[0] ? ((c >> 1) ^ ptp_tc_pkg::CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  // signed ns to scaled ns
  function automatic logic [63:0] sx(input logic [31:0] x);
    return {{16{x[31]}}, x, 16'h0000};
  endfunction

  // difference wrapped into one second
  function automatic logic [31:0] md(input logic [31:0] a, input logic [31:0] b);
    logic [31:0] d;
    d = a - b;
    return d[31] ? d + ptp_tc_pkg::NS_PER_SEC : d;
  endfunction

  // one frame through the block: cf at byte 8, reserved at byte 16, fcs after byte 23
  task automatic run(input ptp_tc_pkg::tc_action_t a, input ptp_tc_pkg::asym_sel_t s,
    input logic [63:0] cf, input logic [31:0] rsv, input logic [31:0] raw, input logic bad,
    input logic [63:0] ecf, input logic [31:0] ersv, input logic wr, input logic [1:0] m);
    logic [7:0]  f[$];
    logic [7:0]  e[$];
    logic [31:0] c;
    logic        ok;
    int          n;
    f = {};
    for (int i = 0; i < 24; i++)
      f.push_back(8'h10 + 8'(i));
    for (int i = 0; i < 8; i++)
      f[8 + i] = cf[63 - 8 * i -: 8];
    for (int i = 0; i < 4; i++)
      f[16 + i] = rsv[31 - 8 * i -: 8];
    e = f;
    for (int i = 0; i < 8; i++)
      e[8 + i] = ecf[63 - 8 * i -: 8];
    for (int i = 0; i < 4; i++)
      e[16 + i] = ersv[31 - 8 * i -: 8];
    c = ~crc_of(f) ^ {31'h0, bad};
    for (int i = 0; i < 4; i++)
      f.push_back(c[8 * i +: 8]);
    c = wr ? (crc_of(e) ^ (bad ? 32'h00000000 : 32'hFFFFFFFF)) : c;
    for (int i = 0; i < 4; i++)
      e.push_back(c[8 * i +: 8]);
    mode = m;
    desc_i = '{a, s, cf, rsv, 16'h0008, 16'h0010, 16'h0A5C};
    raw_nanosecond_stamp_i = raw;
    far_end_sink_i.rx_q.delete();
    first_wait = -1;
    for (int i = 0; i < f.size(); i++)
    begin
      in_valid_i = 1'b1;
      in_beat_i = '{f[i], i == f.size() - 1};
      desc_valid_i = (i == 0);
      n = 0;
      do
      begin
        @(negedge ref_clk_i);
        ok = in_ready_o;
        if (i == 1 && n == 0)
        begin
          sv = ts_save_o;
          fl = stamp_flush_o;
          rec = ts_rec_o;
        end
        if (i == 0 && ok)
          chk("desc_ready", 64'h1, {63'h0, desc_ready_o});
        n++;
        @(posedge ref_clk_i);
        #1;
      end
      while (!ok && n < 200);
      if (n > 1 && first_wait < 0)
        first_wait = i;
      if (!ok)
      begin
        bad_count++;
        report_and_stop();
      end
    end
    in_valid_i = 1'b0;
    desc_valid_i = 1'b0;
    n = 0;
    while (far_end_sink_i.rx_q.size() < e.size() && n < 400)
    begin
      @(posedge ref_clk_i);
      n++;
    end
    #1;
    chk("frame_len", 64'(e.size()), 64'(far_end_sink_i.rx_q.size()));
    if (far_end_sink_i.rx_q.size() != e.size())
      report_and_stop();
    foreach (e[i])
      chk("out_byte", 64'(e[i]), 64'(far_end_sink_i.rx_q[i].data));
    chk("last_flag", 64'h1, {63'h0, far_end_sink_i.rx_q[e.size() - 1].last});
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_e2e_sync;
    run(ptp_tc_pkg::ACT_E2E_B, ptp_tc_pkg::ASYM_NONE, 64'h0000000000120000, 32'h00001000,
      32'h00003000, 1'b0, 64'h0000000000120000 + sx(md(32'h00003064, 32'h00001000)),
      32'h00000000, 1'b1, 2'h1);
  endtask

  // software t3 just under a second back, zero cf: the difference wraps
  task automatic t_e2e_dreq_wrap;
    run(ptp_tc_pkg::ACT_E2E_B, ptp_tc_pkg::ASYM_SUB, 64'h0, 32'h3B9AC9F0, 32'h00000010,
      1'b0, sx(md(32'h00000074, 32'h3B9AC9F0)) - sx(32'h0000000A), 32'h00000000, 1'b1,
      2'h0);
  endtask

  task automatic t_peer_sync;
    run(ptp_tc_pkg::ACT_PEER_SUB, ptp_tc_pkg::ASYM_ADD, 64'h0000000001000000, 32'h00000777,
      32'h00000500, 1'b0, 64'h0000000001000000 - sx(32'h0000049C) + sx(32'h000003E8)
      + sx(32'h0000000A), 32'h00000777, 1'b1, 2'h1);
  endtask

  task automatic t_ing_write;
    run(ptp_tc_pkg::ACT_ING_WRITE, ptp_tc_pkg::ASYM_NONE, 64'h0000000000050000, 32'h0,
      32'h00002000, 1'b0, 64'h0000000000050000, 32'h00001F9C, 1'b1, 2'h0);
    run(ptp_tc_pkg::ACT_ING_WRITE, ptp_tc_pkg::ASYM_ADD, 64'h0000000000050000, 32'h0,
      32'h00002000, 1'b0, 64'h0000000000050000 + sx(32'h0000000A), 32'h00001F9C, 1'b1,
      2'h1);
  endtask

  task automatic t_egr_sync_bad_fcs;
    run(ptp_tc_pkg::ACT_EGR_ADD, ptp_tc_pkg::ASYM_NONE, 64'hFFFFFFFFFF000000, 32'h00000123,
      32'h00000400, 1'b1, 64'hFFFFFFFFFF000000 + sx(32'h00000464), 32'h00000123, 1'b1,
      2'h1);
  endtask

  task automatic t_egr_sub_add;
    run(ptp_tc_pkg::ACT_EGR_SUB_ADD, ptp_tc_pkg::ASYM_SUB, 64'h0, 32'h00000300, 32'h00000900,
      1'b0, sx(32'h00000664) - sx(32'h0000000A), 32'h00000300, 1'b1, 2'h0);
    run(ptp_tc_pkg::ACT_EGR_SUB_ADD, ptp_tc_pkg::ASYM_NONE, 64'h0000000000330000,
      32'h3B9AC000, 32'h00000100, 1'b0, 64'h0000000000330000
      + sx(md(32'h00000164, 32'h3B9AC000)), 32'h3B9AC000, 1'b1, 2'h1);
  endtask

  task automatic t_write_save;
    run(ptp_tc_pkg::ACT_WRITE_SAVE, ptp_tc_pkg::ASYM_NONE, 64'h0, 32'h00000055, 32'h00000A00,
      1'b0, 64'h0, 32'h00000055, 1'b0, 2'h0);
    chk("ts_save", 64'h1, {63'h0, sv});
    chk("ts_rec", {16'h0, 16'h0A5C, 32'h00000A64}, {16'h0, rec});
  endtask

  task automatic t_pass;
    run(ptp_tc_pkg::ACT_PASS, ptp_tc_pkg::ASYM_ADD, 64'h0000000000770000, 32'h00000099,
      32'h00000B00, 1'b1, 64'h0000000000770000, 32'h00000099, 1'b0, 2'h1);
    chk("flush", 64'h1, {63'h0, fl});
    chk("no_save", 64'h0, {63'h0, sv});
  endtask

  // receiver stalled: four held bytes plus two buffer entries, then refusal
  task automatic t_backpressure;
    run(ptp_tc_pkg::ACT_EGR_ADD, ptp_tc_pkg::ASYM_NONE, 64'h0, 32'h0, 32'h00000200, 1'b0,
      sx(32'h00000264), 32'h0, 1'b1, 2'h2);
    chk("first_refusal", 64'h6, 64'(first_wait));
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge ref_clk_i);
    #1;
    reset_i = 1'b0;
    t_e2e_sync();
    t_e2e_dreq_wrap();
    t_peer_sync();
    t_ing_write();
    t_egr_sync_bad_fcs();
    t_egr_sub_add();
    t_write_save();
    t_pass();
    t_backpressure();
    report_and_stop();
  end
endmodule

`default_nettype wire
